// >>> src/dod_decoder.sv
// Instruction decoder top: fetch sequencing, second-word capture and decoded outputs
`timescale 1ns/1ps

module dod_decoder
#(
   parameter int PC_W = 16
)
(
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   input  wire logic                 pm_valid,
   input  wire logic [15:0]          pm_word,
   input  wire logic                 cond_true,
   output logic                      pm_ready,
   output logic      [PC_W-1:0]      pc,
   output logic                      dec_valid,
   output dod_pkg::dod_op_t          dec_op,
   output dod_pkg::dod_sc_t          dec_sel,
   output logic      [1:0]           dec_words,
   output logic      [2:0]           dec_cycles,
   output logic      [15:0]          dec_imm,
   output logic      [7:0]           dec_addr,
   output logic      [3:0]           dec_shift,
   output logic      [2:0]           dec_ar,
   output logic      [7:0]           dec_cond,
   output logic                      dec_illegal
);

   // ******************************************************************
   // Declarations
   // ******************************************************************
   dod_pkg::dod_state_t state_r;
   dod_pkg::dod_op_t    m_op;
   dod_pkg::dod_sc_t    m_sel;
   logic [1:0]          m_words;
   logic [2:0]          m_cyc;
   logic [2:0]          m_cyc_alt;
   logic                m_legal;
   logic [15:0]         first_r;
   logic                take;
   logic                need_second;

   // Pattern match on the incoming word, only meaningful in first-word state
   dod_match u_match
   (
      .word    (pm_word),
      .op      (m_op),
      .sel     (m_sel),
      .words   (m_words),
      .cyc     (m_cyc),
      .cyc_alt (m_cyc_alt),
      .legal   (m_legal)
   );

   // Always ready while clocked; the program memory is the only stall source
   assign pm_ready    = ce;
   assign take        = ce && pm_valid;
   assign need_second = (m_words == dod_pkg::DOD_WORDS_2);

   // ******************************************************************
   // Fetch sequencer
   // ******************************************************************
   // A second word is only captured, never matched, so data cannot alias an opcode
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         state_r <= dod_pkg::DOD_ST_FIRST;
      else if (take)
      begin
         case (state_r)
            dod_pkg::DOD_ST_FIRST:
               state_r <= need_second ? dod_pkg::DOD_ST_SECOND : dod_pkg::DOD_ST_FIRST;
            dod_pkg::DOD_ST_SECOND:
               state_r <= dod_pkg::DOD_ST_FIRST;
            default:
               state_r <= dod_pkg::DOD_ST_FIRST;
         endcase
      end
   end

   // Program counter: one step per word taken, so two-word forms advance by two
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pc <= PC_W'(dod_pkg::DOD_PC_RESET);
      else if (take)
         pc <= pc + PC_W'(1);
   end

   // Hold the first word while its constant is fetched
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         first_r <= 16'h0000;
      else if (take && state_r == dod_pkg::DOD_ST_FIRST)
         first_r <= pm_word;
   end

   // ******************************************************************
   // Decoded outputs
   // ******************************************************************
   // Strobe for one enabled cycle when a whole instruction is in hand; it keeps its value while ce is low
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         dec_valid <= 1'b0;
      else if (ce)
         dec_valid <= pm_valid && ((state_r == dod_pkg::DOD_ST_SECOND) || !need_second);
   end

   // Field outputs load with the first word; the constant loads with the second
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dec_op      <= dod_pkg::DOD_OP_NONE;
         dec_sel     <= dod_pkg::DOD_SC_NONE;
         dec_words   <= dod_pkg::DOD_WORDS_1;
         dec_cycles  <= dod_pkg::DOD_CYC_1;
         dec_addr    <= 8'h00;
         dec_shift   <= 4'h0;
         dec_ar      <= 3'h0;
         dec_cond    <= 8'h00;
         dec_illegal <= 1'b0;
      end
      else if (take && state_r == dod_pkg::DOD_ST_FIRST)
      begin
         dec_op      <= m_op;
         dec_sel     <= m_sel;
         dec_words   <= m_words;
         // Return cost depends on the condition judged by the datapath
         dec_cycles  <= cond_true ? m_cyc : m_cyc_alt;
         dec_addr    <= pm_word[7:0];
         // Shift count sits low for immediate OR, in bits 10:8 for stores
         dec_shift   <= (m_op == dod_pkg::DOD_OP_OR_IMM_SHIFT) ? pm_word[3:0]
                        : {1'b0, pm_word[10:8]};
         dec_ar      <= pm_word[2:0];
         dec_cond    <= pm_word[7:0];
         dec_illegal <= !m_legal;
      end
   end

   // Immediate: second word for two-word forms, else the low byte zero-extended
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         dec_imm <= 16'h0000;
      else if (take && state_r == dod_pkg::DOD_ST_SECOND)
         dec_imm <= pm_word;
      else if (take)
         dec_imm <= {8'h00, pm_word[7:0]};
   end

   // ******************************************************************
   // Checks
   // ******************************************************************
   chk_second_no_strobe: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && need_second) |=> !dec_valid)
      else $error("strobe raised on first word of two-word instruction");

   chk_pc_step_two: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && need_second) ##1 take |=> pc == $past(pc, 2) + PC_W'(2))
      else $error("program counter did not advance by two");

   chk_mac_move: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && pm_word[15:8] == dod_pkg::DOD_UB_MAC_MOVE)
      |=> dec_op == dod_pkg::DOD_OP_MAC_MOVE && dec_cycles == dod_pkg::DOD_CYC_3 && dec_words == dod_pkg::DOD_WORDS_2)
      else $error("multiply-accumulate-move decode wrong");

   chk_addr_pass: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST) |=> dec_addr == $past(pm_word[7:0]))
      else $error("address byte altered");

   chk_ret_cycles: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && pm_word[15:10] == dod_pkg::DOD_RET_HI6 && !cond_true
       && pm_word != dod_pkg::DOD_RET_UNCOND) |=> dec_cycles == dod_pkg::DOD_CYC_2)
      else $error("untaken return cycle count wrong");

   chk_imm_capture: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && pm_word[15:8] == dod_pkg::DOD_UB_STORE_IMM) ##1 take
      |=> dec_valid && dec_imm == $past(pm_word) && dec_op == dod_pkg::DOD_OP_STORE_IMM)
      else $error("store constant not captured from second word");

   chk_store_half: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && pm_word[15:12] == dod_pkg::DOD_NIB_STORE)
      |=> dec_op == ($past(pm_word[11]) ? dod_pkg::DOD_OP_STORE_HIGH : dod_pkg::DOD_OP_STORE_LOW))
      else $error("store half selection wrong");

   chk_single_strobe: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && pm_word == {dod_pkg::DOD_UB_MISC_GRP, dod_pkg::DOD_LB_ACC_PROD})
      |=> dec_valid && dec_op == dod_pkg::DOD_OP_ACC_FROM_PROD && dec_cycles == dod_pkg::DOD_CYC_1)
      else $error("product-to-accumulator decode wrong");

   // The constant must not disturb what the held first word decoded to
   chk_second_held: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_SECOND)
      |=> dec_op == $past(dec_op) && dec_addr == first_r[7:0])
      else $error("second word disturbed the decoded fields");

   chk_set_carry: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST
       && pm_word == {dod_pkg::DOD_UB_MISC_GRP, dod_pkg::DOD_NIB_SET_CTL, dod_pkg::DOD_SC_N_CARRY})
      |=> dec_valid && dec_op == dod_pkg::DOD_OP_SET_CONTROL && dec_sel == dod_pkg::DOD_SC_CARRY)
      else $error("set carry control decode wrong");

   chk_ret_taken: assert property (@(posedge clk) disable iff (!nrst)
      (take && state_r == dod_pkg::DOD_ST_FIRST && pm_word[15:10] == dod_pkg::DOD_RET_HI6 && cond_true)
      |=> dec_cycles == dod_pkg::DOD_CYC_4)
      else $error("taken return cycle count wrong");

endmodule

// >>> src/dod_pkg.sv
// Package of opcode patterns, counts and operation codes for the instruction decoder
package dod_pkg;

   // ******************************************************************
   // Operation codes
   // ******************************************************************
   typedef enum logic [5:0] {
      DOD_OP_NONE          = 6'h00,
      DOD_OP_MAC_MOVE      = 6'h01,
      DOD_OP_LOAD_ARP      = 6'h02,
      DOD_OP_MULTIPLY      = 6'h03,
      DOD_OP_MPY_ADD_PREV  = 6'h04,
      DOD_OP_MPY_SUB_PREV  = 6'h05,
      DOD_OP_NORMALIZE     = 6'h06,
      DOD_OP_OR_IMM_SHIFT  = 6'h07,
      DOD_OP_OR_IMM_16     = 6'h08,
      DOD_OP_ACC_FROM_PROD = 6'h09,
      DOD_OP_POP_ACC       = 6'h0A,
      DOD_OP_POP_MEM       = 6'h0B,
      DOD_OP_PUSH_MEM      = 6'h0C,
      DOD_OP_PUSH_ACC      = 6'h0D,
      DOD_OP_COND_RETURN   = 6'h0E,
      DOD_OP_REPEAT_MEM    = 6'h0F,
      DOD_OP_REPEAT_IMM    = 6'h10,
      DOD_OP_STORE_HIGH    = 6'h11,
      DOD_OP_STORE_LOW     = 6'h12,
      DOD_OP_AUX_SUB_IMM   = 6'h13,
      DOD_OP_SET_CONTROL   = 6'h14,
      DOD_OP_SQUARE_ADD    = 6'h15,
      DOD_OP_SQUARE_SUB    = 6'h16,
      DOD_OP_STORE_STAT0   = 6'h17,
      DOD_OP_STORE_STAT1   = 6'h18,
      DOD_OP_STORE_IMM     = 6'h19,
      DOD_OP_SUB_PRODUCT   = 6'h1A
   } dod_op_t;

   // Status control selectors
   typedef enum logic [2:0] {
      DOD_SC_NONE  = 3'h0,
      DOD_SC_CARRY = 3'h1,
      DOD_SC_PROG  = 3'h2,
      DOD_SC_INTD  = 3'h3,
      DOD_SC_OVM   = 3'h4,
      DOD_SC_TEST  = 3'h5,
      DOD_SC_XFLAG = 3'h6,
      DOD_SC_SXM   = 3'h7
   } dod_sc_t;

   // Fetch states, one-hot
   typedef enum logic [1:0] {
      DOD_ST_FIRST  = 2'b01,
      DOD_ST_SECOND = 2'b10
   } dod_state_t;

   // ******************************************************************
   // Upper-byte patterns
   // ******************************************************************
   localparam logic [7:0] DOD_UB_MAC_MOVE  = 8'hA3;
   localparam logic [7:0] DOD_UB_MAR_GRP   = 8'h8B;
   localparam logic [7:0] DOD_UB_MULTIPLY  = 8'h54;
   localparam logic [7:0] DOD_UB_MPY_ADD   = 8'h50;
   localparam logic [7:0] DOD_UB_MPY_SUB   = 8'h51;
   localparam logic [7:0] DOD_UB_NORMALIZE = 8'hA0;
   localparam logic [7:0] DOD_UB_IMM_GRP   = 8'hBF;
   localparam logic [7:0] DOD_UB_MISC_GRP  = 8'hBE;
   localparam logic [7:0] DOD_UB_POP_MEM   = 8'h8A;
   localparam logic [7:0] DOD_UB_PUSH_MEM  = 8'h76;
   localparam logic [7:0] DOD_UB_REP_MEM   = 8'h0B;
   localparam logic [7:0] DOD_UB_REP_IMM   = 8'hBB;
   localparam logic [7:0] DOD_UB_AUX_SUB   = 8'h7C;
   localparam logic [7:0] DOD_UB_SQR_ADD   = 8'h52;
   localparam logic [7:0] DOD_UB_SQR_SUB   = 8'h53;
   localparam logic [7:0] DOD_UB_STAT0     = 8'h8E;
   localparam logic [7:0] DOD_UB_STAT1     = 8'h8F;
   localparam logic [7:0] DOD_UB_STORE_IMM = 8'hAE;

   // Other field patterns
   localparam logic [4:0] DOD_ARP_HI5      = 5'h11;   // Low byte 1000 1xxx
   localparam logic [3:0] DOD_NIB_OR_SHIFT = 4'hC;
   localparam logic [7:0] DOD_LB_OR_16     = 8'h82;
   localparam logic [7:0] DOD_LB_ACC_PROD  = 8'h03;
   localparam logic [7:0] DOD_LB_POP       = 8'h32;
   localparam logic [7:0] DOD_LB_PUSH      = 8'h3C;
   localparam logic [7:0] DOD_LB_SUB_PROD  = 8'h05;
   localparam logic [3:0] DOD_NIB_SET_CTL  = 4'h4;
   localparam logic [5:0] DOD_RET_HI6      = 6'h3B;   // 1110 11
   localparam logic [3:0] DOD_NIB_STORE    = 4'h9;
   localparam logic [3:0] DOD_SC_N_CARRY   = 4'hF;
   localparam logic [3:0] DOD_SC_N_PROG    = 4'h5;
   localparam logic [3:0] DOD_SC_N_INTD    = 4'h1;
   localparam logic [3:0] DOD_SC_N_OVM     = 4'h3;
   localparam logic [3:0] DOD_SC_N_TEST    = 4'hB;
   localparam logic [3:0] DOD_SC_N_XFLAG   = 4'hD;
   localparam logic [3:0] DOD_SC_N_SXM     = 4'h7;
   localparam logic [15:0] DOD_RET_UNCOND  = 16'hEF00;

   // ******************************************************************
   // Word and cycle counts
   // ******************************************************************
   localparam logic [1:0] DOD_WORDS_1  = 2'h1;
   localparam logic [1:0] DOD_WORDS_2  = 2'h2;
   localparam logic [2:0] DOD_CYC_1    = 3'h1;
   localparam logic [2:0] DOD_CYC_2    = 3'h2;
   localparam logic [2:0] DOD_CYC_3    = 3'h3;
   localparam logic [2:0] DOD_CYC_4    = 3'h4;
   localparam logic [15:0] DOD_PC_RESET = 16'h0000;

endpackage

// >>> src/dod_match.sv
// Combinational opcode match for the multiply-to-subtract instruction range
`timescale 1ns/1ps

module dod_match
(
   input  wire logic [15:0]      word,
   output dod_pkg::dod_op_t      op,
   output dod_pkg::dod_sc_t      sel,
   output logic      [1:0]       words,
   output logic      [2:0]       cyc,
   output logic      [2:0]       cyc_alt,
   output logic                  legal
);

   logic [7:0] ub;
   logic [7:0] lb;

   assign ub = word[15:8];
   assign lb = word[7:0];

   // ******************************************************************
   // Pattern table
   // ******************************************************************
   // Full-word patterns are tested before the shared upper-byte groups, apart from the subtract-product word, which is tested last
   always_comb
   begin
      op      = dod_pkg::DOD_OP_NONE;
      sel     = dod_pkg::DOD_SC_NONE;
      words   = dod_pkg::DOD_WORDS_1;
      cyc     = dod_pkg::DOD_CYC_1;
      cyc_alt = dod_pkg::DOD_CYC_1;
      if (ub == dod_pkg::DOD_UB_MAC_MOVE)
      begin
         op    = dod_pkg::DOD_OP_MAC_MOVE;
         words = dod_pkg::DOD_WORDS_2;
         cyc   = dod_pkg::DOD_CYC_3;
      end
      else if (ub == dod_pkg::DOD_UB_MAR_GRP && lb[7:3] == dod_pkg::DOD_ARP_HI5)
         op = dod_pkg::DOD_OP_LOAD_ARP;
      else if (ub == dod_pkg::DOD_UB_MULTIPLY)
         op = dod_pkg::DOD_OP_MULTIPLY;
      else if (ub == dod_pkg::DOD_UB_MPY_ADD)
         op = dod_pkg::DOD_OP_MPY_ADD_PREV;
      else if (ub == dod_pkg::DOD_UB_MPY_SUB)
         op = dod_pkg::DOD_OP_MPY_SUB_PREV;
      else if (ub == dod_pkg::DOD_UB_NORMALIZE)
         op = dod_pkg::DOD_OP_NORMALIZE;
      else if (ub == dod_pkg::DOD_UB_IMM_GRP && lb[7:4] == dod_pkg::DOD_NIB_OR_SHIFT)
      begin
         op    = dod_pkg::DOD_OP_OR_IMM_SHIFT;
         words = dod_pkg::DOD_WORDS_2;
         cyc   = dod_pkg::DOD_CYC_2;
      end
      else if (ub == dod_pkg::DOD_UB_MISC_GRP && lb == dod_pkg::DOD_LB_OR_16)
      begin
         op    = dod_pkg::DOD_OP_OR_IMM_16;
         words = dod_pkg::DOD_WORDS_2;
         cyc   = dod_pkg::DOD_CYC_2;
      end
      else if (ub == dod_pkg::DOD_UB_MISC_GRP && lb == dod_pkg::DOD_LB_ACC_PROD)
         op = dod_pkg::DOD_OP_ACC_FROM_PROD;
      else if (ub == dod_pkg::DOD_UB_MISC_GRP && lb == dod_pkg::DOD_LB_POP)
         op = dod_pkg::DOD_OP_POP_ACC;
      else if (ub == dod_pkg::DOD_UB_POP_MEM)
         op = dod_pkg::DOD_OP_POP_MEM;
      else if (ub == dod_pkg::DOD_UB_PUSH_MEM)
         op = dod_pkg::DOD_OP_PUSH_MEM;
      else if (ub == dod_pkg::DOD_UB_MISC_GRP && lb == dod_pkg::DOD_LB_PUSH)
         op = dod_pkg::DOD_OP_PUSH_ACC;
      else if (word[15:10] == dod_pkg::DOD_RET_HI6)
      begin
         op      = dod_pkg::DOD_OP_COND_RETURN;
         cyc     = dod_pkg::DOD_CYC_4;
         cyc_alt = (word == dod_pkg::DOD_RET_UNCOND) ? dod_pkg::DOD_CYC_4 : dod_pkg::DOD_CYC_2;
      end
      else if (ub == dod_pkg::DOD_UB_REP_MEM)
         op = dod_pkg::DOD_OP_REPEAT_MEM;
      else if (ub == dod_pkg::DOD_UB_REP_IMM)
         op = dod_pkg::DOD_OP_REPEAT_IMM;
      else if (word[15:12] == dod_pkg::DOD_NIB_STORE)
         op = word[11] ? dod_pkg::DOD_OP_STORE_HIGH : dod_pkg::DOD_OP_STORE_LOW;
      else if (ub == dod_pkg::DOD_UB_AUX_SUB)
         op = dod_pkg::DOD_OP_AUX_SUB_IMM;
      else if (ub == dod_pkg::DOD_UB_MISC_GRP && lb[7:4] == dod_pkg::DOD_NIB_SET_CTL)
      begin
         case (lb[3:0])
            dod_pkg::DOD_SC_N_CARRY: sel = dod_pkg::DOD_SC_CARRY;
            dod_pkg::DOD_SC_N_PROG:  sel = dod_pkg::DOD_SC_PROG;
            dod_pkg::DOD_SC_N_INTD:  sel = dod_pkg::DOD_SC_INTD;
            dod_pkg::DOD_SC_N_OVM:   sel = dod_pkg::DOD_SC_OVM;
            dod_pkg::DOD_SC_N_TEST:  sel = dod_pkg::DOD_SC_TEST;
            dod_pkg::DOD_SC_N_XFLAG: sel = dod_pkg::DOD_SC_XFLAG;
            dod_pkg::DOD_SC_N_SXM:   sel = dod_pkg::DOD_SC_SXM;
            default:                 sel = dod_pkg::DOD_SC_NONE;
         endcase
         // Clear forms of this group lie outside the range
         op = (sel == dod_pkg::DOD_SC_NONE) ? dod_pkg::DOD_OP_NONE : dod_pkg::DOD_OP_SET_CONTROL;
      end
      else if (ub == dod_pkg::DOD_UB_SQR_ADD)
         op = dod_pkg::DOD_OP_SQUARE_ADD;
      else if (ub == dod_pkg::DOD_UB_SQR_SUB)
         op = dod_pkg::DOD_OP_SQUARE_SUB;
      else if (ub == dod_pkg::DOD_UB_STAT0)
         op = dod_pkg::DOD_OP_STORE_STAT0;
      else if (ub == dod_pkg::DOD_UB_STAT1)
         op = dod_pkg::DOD_OP_STORE_STAT1;
      else if (ub == dod_pkg::DOD_UB_STORE_IMM)
      begin
         op    = dod_pkg::DOD_OP_STORE_IMM;
         words = dod_pkg::DOD_WORDS_2;
         cyc   = dod_pkg::DOD_CYC_2;
      end
      else if (ub == dod_pkg::DOD_UB_MISC_GRP && lb == dod_pkg::DOD_LB_SUB_PROD)
         op = dod_pkg::DOD_OP_SUB_PRODUCT;
      if (op == dod_pkg::DOD_OP_NONE)
         cyc_alt = dod_pkg::DOD_CYC_1;
      else if (op != dod_pkg::DOD_OP_COND_RETURN)
         cyc_alt = cyc;
   end

   assign legal = (op != dod_pkg::DOD_OP_NONE);

endmodule

// >>> verification/dod_pm_model.sv
// Program memory model that feeds instruction words to the decoder
`timescale 1ns/1ps

module dod_pm_model
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        pm_ready,
   output logic             pm_valid,
   output logic [15:0]      pm_word
);
   logic [15:0] q[$];

   // Bench fills the queue; an empty queue is a slow memory
   task automatic put(input logic [15:0] w);
      q.push_back(w);
   endtask

   // One word leaves per accepted edge; idle bus shows a toggling pattern so stale data never looks valid
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pm_valid <= 1'b0;
         pm_word  <= 16'h0000;
      end
      else
      begin
         if (pm_valid && pm_ready)
            void'(q.pop_front());
         if (q.size() > 0)
         begin
            pm_valid <= 1'b1;
            pm_word  <= q[0];
         end
         else
         begin
            pm_valid <= 1'b0;
            pm_word  <= ~pm_word;
         end
      end
   end
endmodule

// >>> verification/tb_dod_decoder.sv
// Self-checking testbench for the instruction decoder
`timescale 1ns/1ps

module tb_dod_decoder;
   logic             clk, nrst, ce, cond_true, pm_valid, pm_ready, dec_valid, dec_illegal;
   logic [15:0]      pm_word, pc, dec_imm, p0;
   logic [7:0]       dec_addr, dec_cond;
   logic [3:0]       dec_shift;
   logic [2:0]       dec_cycles, dec_ar;
   logic [1:0]       dec_words;
   dod_pkg::dod_op_t dec_op;
   dod_pkg::dod_sc_t dec_sel;
   int               n_errors, n_tests;

   // 100 MHz clock
   always #5 clk = ~clk;

   dod_pm_model i_dod_pm_model (.clk(clk), .nrst(nrst), .pm_ready(pm_ready), .pm_valid(pm_valid), .pm_word(pm_word));

   dod_decoder i_dod_decoder (.clk(clk), .nrst(nrst), .ce(ce), .pm_valid(pm_valid), .pm_word(pm_word),
      .cond_true(cond_true), .pm_ready(pm_ready), .pc(pc), .dec_valid(dec_valid), .dec_op(dec_op),
      .dec_sel(dec_sel), .dec_words(dec_words), .dec_cycles(dec_cycles), .dec_imm(dec_imm),
      .dec_addr(dec_addr), .dec_shift(dec_shift), .dec_ar(dec_ar), .dec_cond(dec_cond),
      .dec_illegal(dec_illegal));

   // ******************************************************************
   // Shared helpers
   // ******************************************************************
   task automatic give_verdict();
      $display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic push(input logic [15:0] w);
      i_dod_pm_model.put(w);
   endtask

   // Bounded wait for the decoded pulse; a hang ends the run as a mismatch
   task automatic wait_dec();
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (dec_valid !== 1'b1 && k < 50);
      if (dec_valid !== 1'b1)
      begin
         n_errors++;
         give_verdict();
      end
   endtask

   // Compare one decoded instruction against its first and second word
   task automatic exp_dec(input logic [15:0] w, input logic [15:0] s, input dod_pkg::dod_op_t op,
                          input logic [1:0] wd, input logic [2:0] cy);
      wait_dec();
      chk(16'(dec_op), 16'(op));
      chk(16'(dec_words), 16'(wd));
      chk(16'(dec_cycles), 16'(cy));
      chk(dec_imm, (wd == 2'h2) ? s : {8'h00, w[7:0]});
      chk(16'(dec_addr), 16'(w[7:0]));
      chk(16'(dec_ar), 16'(w[2:0]));
      chk(16'(dec_cond), 16'(w[7:0]));
      chk(16'(dec_shift), (op == dod_pkg::DOD_OP_OR_IMM_SHIFT) ? 16'(w[3:0]) : 16'(w[10:8]));
      chk(16'(dec_illegal), 16'h0000);
   endtask

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic t_one_word();
      logic [15:0]      w[20] = '{16'h8B8D, 16'h5412, 16'h5023, 16'h5134, 16'hA045, 16'hBE03, 16'hBE32,
                                  16'h8A56, 16'h7667, 16'hBE3C, 16'h0B78, 16'hBB37, 16'h9D34, 16'h9234,
                                  16'h7C89, 16'h529A, 16'h53AB, 16'h8EBC, 16'h8FCD, 16'hBE05};
      dod_pkg::dod_op_t o[20] = '{dod_pkg::DOD_OP_LOAD_ARP, dod_pkg::DOD_OP_MULTIPLY,
         dod_pkg::DOD_OP_MPY_ADD_PREV, dod_pkg::DOD_OP_MPY_SUB_PREV, dod_pkg::DOD_OP_NORMALIZE,
         dod_pkg::DOD_OP_ACC_FROM_PROD, dod_pkg::DOD_OP_POP_ACC, dod_pkg::DOD_OP_POP_MEM,
         dod_pkg::DOD_OP_PUSH_MEM, dod_pkg::DOD_OP_PUSH_ACC, dod_pkg::DOD_OP_REPEAT_MEM,
         dod_pkg::DOD_OP_REPEAT_IMM, dod_pkg::DOD_OP_STORE_HIGH, dod_pkg::DOD_OP_STORE_LOW,
         dod_pkg::DOD_OP_AUX_SUB_IMM, dod_pkg::DOD_OP_SQUARE_ADD, dod_pkg::DOD_OP_SQUARE_SUB,
         dod_pkg::DOD_OP_STORE_STAT0, dod_pkg::DOD_OP_STORE_STAT1, dod_pkg::DOD_OP_SUB_PRODUCT};
      logic [3:0]       nib[7] = '{4'hF, 4'h5, 4'h1, 4'h3, 4'hB, 4'hD, 4'h7};
      dod_pkg::dod_sc_t sc[7] = '{dod_pkg::DOD_SC_CARRY, dod_pkg::DOD_SC_PROG, dod_pkg::DOD_SC_INTD,
         dod_pkg::DOD_SC_OVM, dod_pkg::DOD_SC_TEST, dod_pkg::DOD_SC_XFLAG, dod_pkg::DOD_SC_SXM};
      p0 = pc;
      // Whole table streamed back to back, one word per cycle
      foreach (w[i])
         push(w[i]);
      foreach (nib[i])
         push({12'hBE4, nib[i]});
      foreach (w[i])
         exp_dec(w[i], 16'h0000, o[i], 2'h1, 3'h1);
      foreach (nib[i])
      begin
         exp_dec({12'hBE4, nib[i]}, 16'h0000, dod_pkg::DOD_OP_SET_CONTROL, 2'h1, 3'h1);
         chk(16'(dec_sel), 16'(sc[i]));
      end
      chk(pc, p0 + 16'h001B);
      $display("t_one_word done");
   endtask

   task automatic t_two_word();
      p0 = pc;
      push(16'hA312);
      // Slow memory: nothing is decoded until the constant arrives
      repeat (4) @(posedge clk);
      #1;
      chk(16'(dec_valid), 16'h0000);
      push(16'hABCD);
      push(16'hBFC5);
      push(16'h1357);
      push(16'hBE82);
      push(16'h2468);
      push(16'hAE12);
      push(16'hBE03);
      exp_dec(16'hA312, 16'hABCD, dod_pkg::DOD_OP_MAC_MOVE, 2'h2, 3'h3);
      exp_dec(16'hBFC5, 16'h1357, dod_pkg::DOD_OP_OR_IMM_SHIFT, 2'h2, 3'h2);
      exp_dec(16'hBE82, 16'h2468, dod_pkg::DOD_OP_OR_IMM_16, 2'h2, 3'h2);
      exp_dec(16'hAE12, 16'hBE03, dod_pkg::DOD_OP_STORE_IMM, 2'h2, 3'h2);
      repeat (3) @(posedge clk);
      #1;
      chk(16'(dec_valid), 16'h0000);
      chk(pc, p0 + 16'h0008);
      $display("t_two_word done");
   endtask

   task automatic t_return();
      for (int c = 1; c >= 0; c--)
      begin
         @(posedge clk);
         cond_true <= c[0];
         push(16'hEC33);
         exp_dec(16'hEC33, 16'h0000, dod_pkg::DOD_OP_COND_RETURN, 2'h1, c[0] ? 3'h4 : 3'h2);
      end
      push(16'hEF00);
      exp_dec(16'hEF00, 16'h0000, dod_pkg::DOD_OP_COND_RETURN, 2'h1, 3'h4);
      $display("t_return done");
   endtask

   task automatic t_illegal_freeze();
      push(16'h2000);
      wait_dec();
      chk(16'(dec_illegal), 16'h0001);
      chk(16'(dec_op), 16'(dod_pkg::DOD_OP_NONE));
      p0 = pc;
      @(posedge clk);
      ce <= 1'b0;
      push(16'h5412);
      // Held clock enable: no word taken, nothing decoded
      repeat (4) @(posedge clk);
      #1;
      chk(16'(pm_ready), 16'h0000);
      chk(16'(dec_valid), 16'h0000);
      @(posedge clk);
      ce <= 1'b1;
      #1;
      chk(pc, p0);
      exp_dec(16'h5412, 16'h0000, dod_pkg::DOD_OP_MULTIPLY, 2'h1, 3'h1);
      $display("t_illegal_freeze done");
   endtask

   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      ce = 1'b1;
      cond_true = 1'b0;
      n_errors = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      #1;
      chk(pc, 16'h0000);
      chk(16'(dec_op), 16'(dod_pkg::DOD_OP_NONE));
      chk(16'(dec_valid), 16'h0000);
      @(posedge clk);
      nrst <= 1'b1;
      t_one_word();
      t_two_word();
      t_return();
      t_illegal_freeze();
      give_verdict();
   end
endmodule
